// file: hw/lhis_consts.vh
// Purpose: Constants for the display host interface front end
// Assumes: core_clk at 100 MHz
// Notes: Included by the front end and its sampler
`ifndef LHIS_CONSTS_VH
`define LHIS_CONSTS_VH
`define LHIS_BYTE_W 8
`define LHIS_SYNC_STAGES 3
`define LHIS_SER_SI_BIT 7
`define LHIS_SER_SCL_BIT 6
`define LHIS_BITCNT_W 3
`define LHIS_BITCNT_LAST 3'h7
`define LHIS_BYTE_RST 8'h00
`define LHIS_RD_DATA_RST 8'h00
`endif

// file: hw/lhis_pin_sync.v
// Purpose: Three-stage pin sampler with agreement filter
// Assumes: Inputs asynchronous to core_clk
// Notes: Output changes once stages two and three agree
`timescale 1ns/1ps
`include "lhis_consts.vh"
module lhis_pin_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  core_clk,
  rst_n,
  pin_in,
  pin_out
);
  input wire core_clk;
  input wire rst_n;
  input wire [WIDTH-1:0] pin_in;
  output wire [WIDTH-1:0] pin_out;

  reg [WIDTH-1:0] s1_q;
  reg [WIDTH-1:0] s2_q;
  reg [WIDTH-1:0] s3_q;
  reg [WIDTH-1:0] flt_q;
  genvar i;

  always @(posedge core_clk) begin
    if (!rst_n) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_flt
      always @(posedge core_clk) begin
        if (!rst_n) begin
          flt_q[i] <= RST_VAL[i];
        end else if (s2_q[i] == s3_q[i]) begin
          flt_q[i] <= s3_q[i];
        end
      end
    end
  endgenerate

  assign pin_out = flt_q;
endmodule // lhis_pin_sync

// file: hw/lhis_host_port.v
// Purpose: Host interface front end: 8080, 6800 or four-wire serial
// Assumes: All host pins asynchronous; core_clk 100 MHz
// Notes: Strobe edges are found after three-stage sampling
`timescale 1ns/1ps
`include "lhis_consts.vh"

// Overview of operation
// - Interface-kind strap high selects parallel bus; low selects write-only serial.
// - Bus-style strap high gives 6800 signalling; low gives 8080.
// - Serial data arrives on D7, serial clock on D6.
// - All data lines are released whenever chip select is inactive.
// - 8080 read strobe active low; bus driven only while it is low.
// - 8080 write strobe active low; data captured on its rising edge.
// - 6800 shared read pin is an active-high enable qualifying accesses.
// - 6800 direction pin high means read, low means write.
// - Data/command select high marks display data, low marks control.
// - Settings initialise while hardware reset pin is low, level acting.
// - Transfers accepted only while active-low chip select is low.
// - Parallel mode offers an 8-bit bidirectional data port.
module lhis_host_port #(
  parameter BYTE_W = `LHIS_BYTE_W
) (
  core_clk,
  rst_n,
  parallel_strap,
  bus_style_strap,
  hardware_reset_low,
  chip_select_low,
  data_command_select,
  rd_enable_pin,
  wr_rw_pin,
  data_in,
  data_out,
  data_oe,
  rx_byte,
  rx_is_data,
  rx_valid,
  rd_req,
  rd_is_data,
  rd_data,
  settings_reset
);
  input wire core_clk;
  input wire rst_n;
  input wire parallel_strap;
  input wire bus_style_strap;
  input wire hardware_reset_low;
  input wire chip_select_low;
  input wire data_command_select;
  input wire rd_enable_pin;
  input wire wr_rw_pin;
  input wire [BYTE_W-1:0] data_in;
  output reg [BYTE_W-1:0] data_out;
  output reg [BYTE_W-1:0] data_oe;
  output reg [BYTE_W-1:0] rx_byte;
  output reg rx_is_data;
  output reg rx_valid;
  output reg rd_req;
  output reg rd_is_data;
  input wire [BYTE_W-1:0] rd_data;
  output reg settings_reset;

  // ----------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------
  wire [5:0] ctl_s;
  wire [BYTE_W-1:0] dat_s;
  wire par_s;
  wire s6800_s;
  wire rst_pin_s;
  wire cs_low_s;
  wire dc_s;
  wire rd_s;
  wire wr_s;

  lhis_pin_sync #(.WIDTH(6), .RST_VAL(6'h1F)) u_ctl_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin_in({parallel_strap, bus_style_strap, hardware_reset_low,
             chip_select_low, rd_enable_pin, wr_rw_pin}),
    .pin_out(ctl_s)
  );

  lhis_pin_sync #(.WIDTH(BYTE_W + 1), .RST_VAL({(BYTE_W + 1){1'b0}})) u_dat_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin_in({data_command_select, data_in}),
    .pin_out({dc_s, dat_s})
  );

  assign par_s = ctl_s[5];
  assign s6800_s = ctl_s[4];
  assign rst_pin_s = ctl_s[3];
  assign cs_low_s = ctl_s[2];
  assign rd_s = ctl_s[1];
  assign wr_s = ctl_s[0];

  // ----------------------------------------------------------------
  // Edge history
  // ----------------------------------------------------------------
  reg rd_prev_q;
  reg wr_prev_q;
  reg scl_prev_q;
  reg [BYTE_W-1:0] dat_prev_q;
  reg dc_prev_q;

  // Reset values match the sampler's reset, so no false edge follows reset
  always @(posedge core_clk) begin
    if (!rst_n) begin
      rd_prev_q <= 1'b1;
      wr_prev_q <= 1'b1;
      scl_prev_q <= 1'b0;
      dat_prev_q <= `LHIS_BYTE_RST;
      dc_prev_q <= 1'b0;
    end else begin
      rd_prev_q <= rd_s;
      wr_prev_q <= wr_s;
      scl_prev_q <= dat_s[`LHIS_SER_SCL_BIT];
      dat_prev_q <= dat_s;
      dc_prev_q <= dc_s;
    end
  end

  wire selected = ~cs_low_s & rst_pin_s;
  wire dev_reset = ~rst_pin_s;
  // 8080 write capture uses data held before the rising edge
  wire wr80_rise = par_s & ~s6800_s & ~wr_prev_q & wr_s;
  // 6800 write latches at enable falling edge
  wire e68_fall = par_s & s6800_s & rd_prev_q & ~rd_s & ~wr_s;
  wire rd80_act = par_s & ~s6800_s & ~rd_s;
  // 6800 read drives while enable is high with direction high
  wire rd68_act = par_s & s6800_s & rd_s & wr_s;
  wire rd_start = (rd80_act & rd_prev_q) | (rd68_act & ~rd_prev_q);
  wire scl_rise = ~par_s & ~scl_prev_q & dat_s[`LHIS_SER_SCL_BIT];

  // ----------------------------------------------------------------
  // Serial shifter
  // ----------------------------------------------------------------
  reg [BYTE_W-2:0] sh_q;
  reg [`LHIS_BITCNT_W-1:0] bcnt_q;

  // Partial byte dropped whenever chip select is seen high
  always @(posedge core_clk) begin
    if (!rst_n || dev_reset || !selected || par_s) begin
      sh_q <= {(BYTE_W - 1){1'b0}};
      bcnt_q <= {`LHIS_BITCNT_W{1'b0}};
    end else if (scl_rise) begin
      sh_q <= {sh_q[BYTE_W-3:0], dat_s[`LHIS_SER_SI_BIT]};
      bcnt_q <= bcnt_q + 3'h1;
    end
  end

  wire ser_done = scl_rise & (bcnt_q == `LHIS_BITCNT_LAST);

  // ----------------------------------------------------------------
  // Settings reset
  // ----------------------------------------------------------------
  // Follows the sampled pin level, so a held pin keeps settings cleared
  always @(posedge core_clk) begin
    if (!rst_n) begin
      settings_reset <= 1'b1;
    end else begin
      settings_reset <= dev_reset;
    end
  end

  // ----------------------------------------------------------------
  // Byte delivery
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    if (!rst_n) begin
      rx_byte <= `LHIS_BYTE_RST;
      rx_is_data <= 1'b0;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (!dev_reset && selected) begin
        if (wr80_rise || e68_fall) begin
          rx_byte <= dat_prev_q;
          rx_is_data <= dc_prev_q;
          rx_valid <= 1'b1;
        end else if (ser_done) begin
          rx_byte <= {sh_q, dat_s[`LHIS_SER_SI_BIT]};
          rx_is_data <= dc_s;
          rx_valid <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Read request
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    if (!rst_n) begin
      rd_req <= 1'b0;
      rd_is_data <= 1'b0;
    end else begin
      rd_req <= 1'b0;
      if (!dev_reset && selected && rd_start) begin
        rd_req <= 1'b1;
        rd_is_data <= dc_s;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read drive
  // ----------------------------------------------------------------
  // Released the cycle after the strobe or chip select is seen to end
  always @(posedge core_clk) begin
    if (!rst_n) begin
      data_out <= `LHIS_RD_DATA_RST;
      data_oe <= {BYTE_W{1'b0}};
    end else if (!dev_reset && selected && (rd80_act || rd68_act)) begin
      data_oe <= {BYTE_W{1'b1}};
      data_out <= rd_data;
    end else begin
      data_oe <= {BYTE_W{1'b0}};
    end
  end
endmodule // lhis_host_port

// file: dv/lhis_host_port_monitor.sv
// Purpose: Port checker for lhis_host_port
// Assumes: Pin sampling delay under 7 cycles
// Notes: Bound from tb
`timescale 1ns/1ps
module lhis_host_port_monitor (
  input wire core_clk,
  input wire rst_n,
  input wire parallel_strap,
  input wire bus_style_strap,
  input wire hardware_reset_low,
  input wire chip_select_low,
  input wire rd_enable_pin,
  input wire wr_rw_pin,
  input wire [7:0] data_oe,
  input wire rx_valid,
  input wire rd_req,
  input wire settings_reset
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence cs_idle;
    chip_select_low [*8];
  endsequence
  a_cs_release: assert property (cs_idle |-> data_oe == 8'h00)
    else $error("bus driven while deselected");
  a_cs_refuse: assert property (cs_idle |-> !rx_valid && !rd_req)
    else $error("transfer while deselected");
  a_serial_quiet: assert property (
    !parallel_strap [*8] |-> data_oe == 8'h00 && !rd_req)
    else $error("bus driven in serial mode");
  a_strobe_idle: assert property (
    (rd_enable_pin ^ bus_style_strap) [*8] |-> data_oe == 8'h00)
    else $error("bus driven without read strobe");
  a_write_dir: assert property (
    (bus_style_strap && !wr_rw_pin) [*8] |-> data_oe == 8'h00 && !rd_req)
    else $error("bus driven in write direction");
  a_oe_whole: assert property (data_oe == 8'h00 || data_oe == 8'hFF)
    else $error("partial byte drive");
  a_rx_single: assert property (rx_valid |=> !rx_valid)
    else $error("byte taken twice");
  a_reset_level: assert property (
    $stable(hardware_reset_low) [*8] |-> settings_reset == !hardware_reset_low)
    else $error("settings reset not following pin");
endmodule // lhis_host_port_monitor

// file: dv/lhis_host_model.sv
// Purpose: Host processor model for lhis_host_port
// Assumes: Pins move just after core_clk edges
// Notes: Link clock 160 ns, idles low between frames
`timescale 1ns/1ps
module lhis_host_model (
  input wire core_clk,
  input wire [7:0] bus,
  output reg chip_select_low = 1'b1,
  output reg data_command_select = 1'b0,
  output reg rd_enable_pin = 1'b1,
  output reg wr_rw_pin = 1'b1,
  output reg [7:0] host_d = 8'h3F,
  output reg [7:0] rd_got = 8'h00
);
  task cyc(input integer n);
    repeat (n) @(posedge core_clk);
  endtask
  // Parallel access: m 6800 style, w write, c chip select level
  task par(input m, input w, input c, input dc, input [7:0] d);
    begin
      chip_select_low <= c;
      data_command_select <= dc;
      host_d <= w ? d : ~host_d;
      rd_enable_pin <= m | w;
      wr_rw_pin <= !w;
      cyc(8);
      rd_got <= bus;
      rd_enable_pin <= !m;
      wr_rw_pin <= m ? !w : 1'b1;
      cyc(10);
      chip_select_low <= 1'b1;
      cyc(4);
    end
  endtask
  task ser(input dc, input [7:0] d);
    integer i;
    begin
      chip_select_low <= 1'b0;
      data_command_select <= dc;
      for (i = 7; i >= 0; i = i - 1) begin
        host_d <= {d[i], 7'h3F};
        cyc(8);
        host_d[6] <= 1'b1;
        cyc(8);
      end
      host_d <= 8'h3F;
      cyc(8);
      chip_select_low <= 1'b1;
      cyc(4);
    end
  endtask
endmodule // lhis_host_model

// file: dv/tb.sv
// Purpose: Self-checking bench for lhis_host_port
// Assumes: Host model drives data and strobe pins; straps and reset pin driven by tb
// Notes: Both bus styles, serial link, refusals
`timescale 1ns/1ps
module tb;
  reg core_clk = 1'b0;
  reg rst_n = 1'b0;
  reg parallel_strap = 1'b1;
  reg bus_style_strap = 1'b0;
  reg hardware_reset_low = 1'b1;
  reg [7:0] rd_data = 8'h5A;
  reg [7:0] got_b = 8'h00;
  reg [7:0] n_rx = 8'h00;
  reg got_dc = 1'b0;
  reg [7:0] n_rd = 8'h00;
  reg got_rd_dc = 1'b0;
  integer n_mismatch = 0;
  integer compares = 0;
  integer n_cyc = 0;
  integer m;
  wire [7:0] data_out, data_oe, rx_byte, host_d, rd_got, bus;
  wire chip_select_low, data_command_select, rd_enable_pin, wr_rw_pin;
  wire rx_is_data, rx_valid, settings_reset, rd_req, rd_is_data;
  assign bus = (data_oe & data_out) | (~data_oe & host_d);
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (rx_valid) begin
      n_rx <= n_rx + 8'h01;
      got_b <= rx_byte;
      got_dc <= rx_is_data;
    end
    if (rd_req) begin
      n_rd <= n_rd + 8'h01;
      got_rd_dc <= rd_is_data;
    end
  end
  lhis_host_model i_host (.core_clk(core_clk), .bus(bus), .chip_select_low(chip_select_low),
    .data_command_select(data_command_select), .rd_enable_pin(rd_enable_pin),
    .wr_rw_pin(wr_rw_pin), .host_d(host_d), .rd_got(rd_got));
  lhis_host_port i_dut (.core_clk(core_clk), .rst_n(rst_n), .parallel_strap(parallel_strap),
    .bus_style_strap(bus_style_strap), .hardware_reset_low(hardware_reset_low),
    .chip_select_low(chip_select_low), .data_command_select(data_command_select),
    .rd_enable_pin(rd_enable_pin), .wr_rw_pin(wr_rw_pin), .data_in(bus),
    .data_out(data_out), .data_oe(data_oe), .rx_byte(rx_byte), .rx_is_data(rx_is_data),
    .rx_valid(rx_valid), .rd_req(rd_req), .rd_is_data(rd_is_data), .rd_data(rd_data),
    .settings_reset(settings_reset));
  task chk(input [8*12:1] nm, input [7:0] seen, input [7:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("mismatch %0s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task conclude;
    begin
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
        $display("[ PASS ]");
      end else begin
        $display("[ FAIL ]");
      end
      $finish;
    end
  endtask
  always @(posedge core_clk) begin
    n_cyc = n_cyc + 1;
    if (n_cyc == 2000) begin
      n_mismatch = n_mismatch + 1;
      conclude;
    end
  end
  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    i_host.cyc(8);
    for (m = 0; m < 2; m = m + 1) begin
      bus_style_strap <= m[0];
      i_host.par(m[0], 1'b1, 1'b1, 1'b1, 8'hFF);
      i_host.par(m[0], 1'b1, 1'b0, 1'b1, 8'hA5);
      chk("rx_byte", got_b, 8'hA5);
      chk("rx_is_data", got_dc, 1'b1);
      i_host.par(m[0], 1'b1, 1'b0, 1'b0, 8'h3C);
      chk("rx_is_data", got_dc, 1'b0);
      i_host.par(m[0], 1'b0, 1'b0, !m[0], 8'h00);
      chk("rd_got", rd_got, 8'h5A);
      chk("rd_is_data", got_rd_dc, !m[0]);
    end
    chk("n_rd", n_rd, 8'h02);
    hardware_reset_low <= 1'b0;
    i_host.par(1'b1, 1'b1, 1'b0, 1'b1, 8'h3F);
    chk("settings_rst", settings_reset, 1'b1);
    chk("rx_byte", got_b, 8'h3C);
    hardware_reset_low <= 1'b1;
    i_host.cyc(8);
    chk("settings_rst", settings_reset, 1'b0);
    parallel_strap <= 1'b0;
    i_host.cyc(8);
    i_host.ser(1'b1, 8'hC3);
    chk("rx_byte", got_b, 8'hC3);
    chk("rx_is_data", got_dc, 1'b1);
    chk("n_rx", n_rx, 8'h05);
    conclude;
  end
endmodule // tb
bind lhis_host_port lhis_host_port_monitor i_mon (.core_clk(core_clk), .rst_n(rst_n),
  .parallel_strap(parallel_strap), .bus_style_strap(bus_style_strap),
  .hardware_reset_low(hardware_reset_low), .chip_select_low(chip_select_low),
  .rd_enable_pin(rd_enable_pin), .wr_rw_pin(wr_rw_pin), .data_oe(data_oe),
  .rx_valid(rx_valid), .rd_req(rd_req), .settings_reset(settings_reset));
